// ===== hw/fscr_regs.sv
`timescale 1ns/1ps
`include "fscr_cfg.svh"

// Summary of operation
// - Busy flag is 1 during program, erase or status write, else 0.
// - Status write, program and erase refused while write latch is 0.
// - Five nonvolatile protect bits, written by status write, select protected region.
// - Guard bits 00 allow status writes once the write latch is set.
// - Guard 10 blocks status writes until power cycle, which clears guard.
// - Guard 11 makes the status register permanently unwritable.
// - Address mode indicator reads 0 in 3-byte, 1 in 4-byte mode.
// - Quad enable always reads 1; writes to it are ignored.
// - Three lock bits default 0, set individually, never clear once set.
// - Suspend sets erase or program suspended flag per suspended operation.
// - Resume, software reset pair and power cycle clear both suspend flags.
// - Dual read dummy setting gives 4 cycles for x0, 8 for x1.
// - Quad read dummy setting gives 6 cycles for x0, 10 for x1.
// - Program fail flag set on failure or protected target, cleared on resume while a program is suspended.
// - Erase fail flag set on failure or protected target, cleared on resume while an erase is suspended.
// - Power-up address bit sampled at init and at software reset; 0 starts 3-byte, 1 4-byte.
// - Drive field 00/01/10/11 gives 100/75/50/25 percent strength.
// - In 3-byte mode the upper address bit selects lower or upper 16 MB.
// - In 4-byte mode the upper address bit is ignored.
// - Write enable sets latch; reset, disable, status write, program, erase clear it.
// - Pin reset restores all volatile bits to power-on defaults.
module fscr_regs
	import fscr_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       resetn,
	input  wire logic       por_n,
	input  wire logic       nv_clear_n,
	input  wire logic       sclk,
	input  wire logic       cs_n,
	input  wire logic       si,
	output logic            so,
	output logic            so_oe,
	input  wire logic       prog_busy,
	input  wire logic       erase_busy,
	input  wire logic       prog_issue,
	input  wire logic       erase_issue,
	input  wire logic       prog_fail,
	input  wire logic       erase_fail,
	output logic            op_busy_flag,
	output logic            write_latch,
	output logic [4:0]      protect_sel,
	output logic            addr_mode_now,
	output logic            quad_io_on,
	output logic            upper_addr_bit,
	output logic            addr_top_bit,
	output logic [2:0]      secure_lock,
	output logic            erase_suspended,
	output logic            program_suspended,
	output logic            program_fail,
	output logic            erase_fail_flag,
	output logic            suspend_pulse,
	output logic            resume_pulse,
	output logic [3:0]      dual_dummy,
	output logic [3:0]      quad_dummy,
	output logic [6:0]      drive_pct
);

	// ***************************************************************
	// Helper functions
	// ***************************************************************

	// Only the low dummy bit matters; the high one is a don't-care
	function automatic logic [3:0] fscr_dummy(input logic [1:0] dc, input logic quad);
		logic [3:0] n;
		n = 4'h0;
		if (quad)
			n = dc[0] ? `FSCR_QUAD_DUMMY_L : `FSCR_QUAD_DUMMY_S;
		else
			n = dc[0] ? `FSCR_DUAL_DUMMY_L : `FSCR_DUAL_DUMMY_S;
		return n;
	endfunction : fscr_dummy

	function automatic logic [6:0] fscr_drive(input logic [1:0] drv);
		logic [6:0] p;
		p = 7'h64;
		case (drv)
			2'b00:   p = 7'h64;
			2'b01:   p = 7'h4b;
			2'b10:   p = 7'h32;
			2'b11:   p = 7'h19;
			default: p = 7'h64;
		endcase
		return p;
	endfunction : fscr_drive

	// ***************************************************************
	// Link side, clocked by the host serial clock
	// ***************************************************************
	fscr_phase_e phase_q;
	fscr_phase_e phase_d;
	logic [2:0]  bit_q;
	logic [6:0]  shift_q;
	logic [7:0]  cmd_q;
	logic [7:0]  dat_q;
	logic        req_tgl_q;
	logic [1:0]  rsel_q;
	logic [7:0]  rd_q;
	logic [31:0] snap1_q;
	logic [31:0] snap2_q;
	logic        frame_rst_n;
	logic [7:0]  byte_in;
	logic        byte_end;
	logic        op_has_data;
	logic        op_is_read;
	logic [1:0]  op_rsel;
	logic [7:0]  snap_byte;
	logic [7:0]  word_byte;
	logic        status_guard_lo_q;
	logic        status_guard_hi_q;
	logic        wel_q;
	logic [31:0] status_word;

	// Frame logic restarts whenever chip select goes high
	assign frame_rst_n = resetn & por_n & ~cs_n;
	assign byte_in     = {shift_q, si};
	assign byte_end    = (bit_q == 3'h7);
	assign op_has_data = (byte_in == `FSCR_OP_WR_SR1) | (byte_in == `FSCR_OP_WR_SR2) |
	                     (byte_in == `FSCR_OP_WR_SR3) | (byte_in == `FSCR_OP_WR_EA);
	assign op_is_read  = (byte_in == `FSCR_OP_RD_SR1) | (byte_in == `FSCR_OP_RD_SR2) |
	                     (byte_in == `FSCR_OP_RD_SR3) | (byte_in == `FSCR_OP_RD_EA);
	assign op_rsel     = (byte_in == `FSCR_OP_RD_SR2) ? 2'h1 :
	                     (byte_in == `FSCR_OP_RD_SR3) ? 2'h2 :
	                     (byte_in == `FSCR_OP_RD_EA)  ? 2'h3 : 2'h0;
	assign word_byte   = (op_is_read & (phase_q == FSCR_PH_OPCODE)) ?
	                     snap2_q[{op_rsel, 3'h0} +: 8] : snap2_q[{rsel_q, 3'h0} +: 8];
	assign snap_byte   = word_byte;

	// Phase sequencing per byte
	always_comb begin
		phase_d = phase_q;
		case (phase_q)
			FSCR_PH_OPCODE: begin
				if (byte_end)
					phase_d = op_has_data ? FSCR_PH_WDATA :
					          op_is_read  ? FSCR_PH_RDATA : FSCR_PH_DONE;
			end
			FSCR_PH_WDATA: begin
				if (byte_end)
					phase_d = FSCR_PH_DONE;
			end
			FSCR_PH_RDATA: phase_d = FSCR_PH_RDATA;
			FSCR_PH_DONE:  phase_d = FSCR_PH_DONE;
			default:       phase_d = FSCR_PH_DONE;
		endcase
	end

	// Per-frame state
	always_ff @(posedge sclk or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			phase_q <= FSCR_PH_OPCODE;
			bit_q   <= 3'h0;
			shift_q <= 7'h00;
			rsel_q  <= 2'h0;
			rd_q    <= 8'h00;
		end else begin
			phase_q <= phase_d;
			bit_q   <= bit_q + 3'h1;
			shift_q <= byte_in[6:0];
			if (byte_end && phase_q == FSCR_PH_OPCODE && op_is_read)
				rsel_q <= op_rsel;
			// Reload each byte so repeated reads show fresh status
			if (byte_end)
				rd_q <= snap_byte;
		end
	end

	// Requests that outlive the frame
	always_ff @(posedge sclk or negedge resetn) begin
		if (!resetn) begin
			cmd_q     <= 8'h00;
			dat_q     <= 8'h00;
			req_tgl_q <= 1'b0;
		end else if (byte_end && phase_q == FSCR_PH_OPCODE) begin
			cmd_q <= byte_in;
			if (!op_has_data && !op_is_read)
				req_tgl_q <= ~req_tgl_q;
		end else if (byte_end && phase_q == FSCR_PH_WDATA) begin
			dat_q     <= byte_in;
			req_tgl_q <= ~req_tgl_q;
		end
	end

	// Status snapshot into the link domain; bits change slowly
	always_ff @(posedge sclk or negedge resetn) begin
		if (!resetn) begin
			snap1_q <= 32'h0000_0000;
			snap2_q <= 32'h0000_0000;
		end else begin
			snap1_q <= status_word;
			snap2_q <= snap1_q;
		end
	end

	// Read data leaves on the falling edge, MSB first
	always_ff @(negedge sclk or negedge frame_rst_n) begin
		if (!frame_rst_n)
			so <= 1'b0;
		else
			so <= rd_q[~bit_q];
	end

	assign so_oe = (phase_q == FSCR_PH_RDATA) & ~cs_n;

	// ***************************************************************
	// Core side: request crossing and command decode
	// ***************************************************************
	logic        vol_rst_n;
	logic        tgl_s1_q;
	logic        tgl_s2_q;
	logic        tgl_s3_q;
	logic        evt;
	logic        pwr_init_q;
	logic        init_q;
	logic        rst_arm_q;
	logic        do_write_enable_cmd;
	logic        do_wrdi;
	logic        do_wsr1;
	logic        do_wsr2;
	logic        do_wsr3;
	logic        do_wea;
	logic        do_en4b;
	logic        do_ex4b;
	logic        do_susp;
	logic        do_resm;
	logic        do_swrst;
	logic        sr_write;
	logic        sr_ok;
	fscr_guard_e guard;

	assign vol_rst_n = resetn & por_n;

	// Toggle handshake; cmd and data stay still for many cycles after it
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			tgl_s1_q <= 1'b0;
			tgl_s2_q <= 1'b0;
			tgl_s3_q <= 1'b0;
		end else begin
			tgl_s1_q <= req_tgl_q;
			tgl_s2_q <= tgl_s1_q;
			tgl_s3_q <= tgl_s2_q;
		end
	end

	assign evt      = tgl_s2_q ^ tgl_s3_q;
	assign do_write_enable_cmd  = evt & (cmd_q == `FSCR_OP_WRITE_ENABLE_CMD);
	assign do_wrdi  = evt & (cmd_q == `FSCR_OP_WRDI);
	assign do_wsr1  = evt & (cmd_q == `FSCR_OP_WR_SR1);
	assign do_wsr2  = evt & (cmd_q == `FSCR_OP_WR_SR2);
	assign do_wsr3  = evt & (cmd_q == `FSCR_OP_WR_SR3);
	assign do_wea   = evt & (cmd_q == `FSCR_OP_WR_EA);
	assign do_en4b  = evt & (cmd_q == `FSCR_OP_EN4B);
	assign do_ex4b  = evt & (cmd_q == `FSCR_OP_EX4B);
	assign do_susp  = evt & (cmd_q == `FSCR_OP_SUSPEND);
	assign do_resm  = evt & (cmd_q == `FSCR_OP_RESUME);
	assign do_swrst = evt & (cmd_q == `FSCR_OP_RST) & rst_arm_q;
	assign sr_write = do_wsr1 | do_wsr2 | do_wsr3;
	assign guard    = fscr_guard_e'({status_guard_hi_q, status_guard_lo_q});
	// Lockdown and one-time modes both refuse; only soft mode honours the latch
	assign sr_ok    = sr_write & wel_q & (guard == FSCR_GUARD_SOFT) & ~op_busy_flag;

	// Reset enable must come right before reset
	always_ff @(posedge clk or negedge vol_rst_n) begin
		if (!vol_rst_n)
			rst_arm_q <= 1'b0;
		else if (evt)
			rst_arm_q <= (cmd_q == `FSCR_OP_RST_EN);
	end

	// Init markers: one released pulse per power-up and per pin or power-up reset
	always_ff @(posedge clk or negedge por_n) begin
		if (!por_n)
			pwr_init_q <= 1'b1;
		else
			pwr_init_q <= 1'b0;
	end

	always_ff @(posedge clk or negedge vol_rst_n) begin
		if (!vol_rst_n)
			init_q <= 1'b1;
		else
			init_q <= 1'b0;
	end

	// ***************************************************************
	// Nonvolatile bits: only the factory clear restores them, except the guard high bit that power-up clears in lockdown
	// ***************************************************************
	logic [4:0] bp_q;
	logic [2:0] lock_q;
	logic [1:0] drv_q;
	logic       adp_q;
	logic [1:0] dc_q;

	always_ff @(posedge clk or negedge nv_clear_n) begin
		if (!nv_clear_n) begin
			bp_q   <= 5'h00;
			status_guard_lo_q <= 1'b0;
			status_guard_hi_q <= 1'b0;
			lock_q <= 3'h0;
			drv_q  <= `FSCR_DRV_RST;
			adp_q  <= 1'b0;
			dc_q   <= `FSCR_DC_RST;
		end else if (pwr_init_q && guard == FSCR_GUARD_LOCK) begin
			status_guard_hi_q <= 1'b0;
		end else if (sr_ok) begin
			// Read-only, fixed and reserved positions are simply not stored
			if (do_wsr1) begin
				bp_q   <= dat_q[`FSCR_SR1_BP_HI:`FSCR_SR1_BP_LO];
				status_guard_lo_q <= dat_q[`FSCR_SR1_GUARD_LO];
			end
			if (do_wsr2) begin
				status_guard_hi_q <= dat_q[`FSCR_SR2_GUARD_HI];
				lock_q <= lock_q | dat_q[`FSCR_SR2_LOCK_HI:`FSCR_SR2_LOCK_LO];
			end
			if (do_wsr3) begin
				drv_q <= dat_q[`FSCR_SR3_DRV_HI:`FSCR_SR3_DRV_LO];
				adp_q <= dat_q[`FSCR_SR3_ADP];
				dc_q  <= dat_q[`FSCR_SR3_DC_HI:`FSCR_SR3_DC_LO];
			end
		end
	end

	// ***************************************************************
	// Volatile bits
	// ***************************************************************
	logic       ads_q;
	logic       a24_q;
	logic       esus_q;
	logic       psus_q;
	logic       pe_q;
	logic       ee_q;
	logic [5:0] srw_cnt_q;

	// Write latch; clearing events win over a same-cycle set
	always_ff @(posedge clk or negedge vol_rst_n) begin
		if (!vol_rst_n)
			wel_q <= 1'b0;
		else if (do_swrst || do_wrdi || sr_ok || prog_issue || erase_issue)
			wel_q <= 1'b0;
		else if (do_write_enable_cmd)
			wel_q <= 1'b1;
	end

	// Status write busy time
	always_ff @(posedge clk or negedge vol_rst_n) begin
		if (!vol_rst_n)
			srw_cnt_q <= 6'h00;
		else if (sr_ok)
			srw_cnt_q <= 6'(`FSCR_SRW_CYC);
		else if (srw_cnt_q != 6'h00)
			srw_cnt_q <= srw_cnt_q - 6'h1;
	end

	// Address mode: boot value taken at init and at software reset
	always_ff @(posedge clk or negedge vol_rst_n) begin
		if (!vol_rst_n) begin
			ads_q <= 1'b0;
			a24_q <= 1'b0;
		end else begin
			if (init_q || do_swrst)
				ads_q <= adp_q;
			else if (do_en4b)
				ads_q <= 1'b1;
			else if (do_ex4b)
				ads_q <= 1'b0;
			if (do_swrst)
				a24_q <= 1'b0;
			else if (do_wea)
				a24_q <= dat_q[`FSCR_EA_A24];
		end
	end

	// Suspend flags
	always_ff @(posedge clk or negedge vol_rst_n) begin
		if (!vol_rst_n) begin
			esus_q <= 1'b0;
			psus_q <= 1'b0;
		end else if (do_resm || do_swrst) begin
			esus_q <= 1'b0;
			psus_q <= 1'b0;
		end else if (do_susp) begin
			esus_q <= esus_q | erase_busy;
			psus_q <= psus_q | prog_busy;
		end
	end

	// Error flags; a failure in the resume cycle still sets
	always_ff @(posedge clk or negedge vol_rst_n) begin
		if (!vol_rst_n) begin
			pe_q <= 1'b0;
			ee_q <= 1'b0;
		end else begin
			if (prog_fail)
				pe_q <= 1'b1;
			else if (do_resm && psus_q)
				pe_q <= 1'b0;
			if (erase_fail)
				ee_q <= 1'b1;
			else if (do_resm && esus_q)
				ee_q <= 1'b0;
		end
	end

	// ***************************************************************
	// Read-back word and outputs
	// ***************************************************************
	logic [7:0]  sr1;
	logic [7:0]  sr2;
	logic [7:0]  sr3;
	logic [7:0]  ear;

	// Reserved bits read zero; quad enable is tied high
	assign sr1 = {status_guard_lo_q, bp_q, wel_q, op_busy_flag};
	assign sr2 = {esus_q, status_guard_hi_q, lock_q, psus_q, 1'b1, ads_q};
	assign sr3 = {1'b0, drv_q, adp_q, ee_q, pe_q, dc_q};
	assign ear = {7'h00, a24_q};
	assign status_word = {ear, sr3, sr2, sr1};

	assign op_busy_flag      = prog_busy | erase_busy | (srw_cnt_q != 6'h00);
	assign write_latch       = wel_q;
	assign protect_sel       = bp_q;
	assign addr_mode_now     = ads_q;
	assign quad_io_on        = 1'b1;
	assign upper_addr_bit    = a24_q;
	assign addr_top_bit      = ads_q ? 1'b0 : a24_q;
	assign secure_lock       = lock_q;
	assign erase_suspended   = esus_q;
	assign program_suspended = psus_q;
	assign program_fail      = pe_q;
	assign erase_fail_flag   = ee_q;

	// Registered data outputs toward the read path
	always_ff @(posedge clk or negedge vol_rst_n) begin
		if (!vol_rst_n) begin
			dual_dummy    <= `FSCR_DUAL_DUMMY_S;
			quad_dummy    <= `FSCR_QUAD_DUMMY_S;
			drive_pct     <= 7'h4b;
			suspend_pulse <= 1'b0;
			resume_pulse  <= 1'b0;
		end else begin
			dual_dummy    <= fscr_dummy(dc_q, 1'b0);
			quad_dummy    <= fscr_dummy(dc_q, 1'b1);
			drive_pct     <= fscr_drive(drv_q);
			suspend_pulse <= do_susp;
			resume_pulse  <= do_resm;
		end
	end

endmodule : fscr_regs

// ===== hw/fscr_cfg.svh
`ifndef FSCR_CFG_SVH
`define FSCR_CFG_SVH

// ***************************************************************
// Command codes
// ***************************************************************
`define FSCR_OP_WRITE_ENABLE_CMD      8'h06
`define FSCR_OP_WRDI      8'h04
`define FSCR_OP_RD_SR1    8'h05
`define FSCR_OP_RD_SR2    8'h35
`define FSCR_OP_RD_SR3    8'h15
`define FSCR_OP_WR_SR1    8'h01
`define FSCR_OP_WR_SR2    8'h31
`define FSCR_OP_WR_SR3    8'h11
`define FSCR_OP_RD_EA     8'hc8
`define FSCR_OP_WR_EA     8'hc5
`define FSCR_OP_EN4B      8'hb7
`define FSCR_OP_EX4B      8'he9
`define FSCR_OP_RST_EN    8'h66
`define FSCR_OP_RST       8'h99
`define FSCR_OP_SUSPEND   8'h75
`define FSCR_OP_RESUME    8'h7a

// ***************************************************************
// Field positions and factory values
// ***************************************************************
`define FSCR_SR1_GUARD_LO 7
`define FSCR_SR1_BP_HI    6
`define FSCR_SR1_BP_LO    2
`define FSCR_SR2_GUARD_HI 6
`define FSCR_SR2_LOCK_HI  5
`define FSCR_SR2_LOCK_LO  3
`define FSCR_SR3_DRV_HI   6
`define FSCR_SR3_DRV_LO   5
`define FSCR_SR3_ADP      4
`define FSCR_SR3_DC_HI    1
`define FSCR_SR3_DC_LO    0
`define FSCR_EA_A24       0
`define FSCR_DRV_RST      2'h1
`define FSCR_DC_RST       2'h0

// ***************************************************************
// Dummy counts and timing
// ***************************************************************
`define FSCR_DUAL_DUMMY_S 4'h4
`define FSCR_DUAL_DUMMY_L 4'h8
`define FSCR_QUAD_DUMMY_S 4'h6
`define FSCR_QUAD_DUMMY_L 4'ha
`define FSCR_CLK_MHZ      20
`define FSCR_SRW_NS       800
`define FSCR_SRW_CYC      ((`FSCR_SRW_NS * `FSCR_CLK_MHZ) / 1000)

`endif

// ===== hw/fscr_pkg.sv
package fscr_pkg;

	// Frame phase at the serial link
	typedef enum logic [1:0] {
		FSCR_PH_OPCODE = 2'b00,
		FSCR_PH_WDATA  = 2'b01,
		FSCR_PH_RDATA  = 2'b10,
		FSCR_PH_DONE   = 2'b11
	} fscr_phase_e;

	// Status write protection modes
	typedef enum logic [1:0] {
		FSCR_GUARD_SOFT = 2'b00,
		FSCR_GUARD_RSVD = 2'b01,
		FSCR_GUARD_LOCK = 2'b10,
		FSCR_GUARD_OTP  = 2'b11
	} fscr_guard_e;

endpackage : fscr_pkg

// ===== verif/fscr_regs_checker.sv
`timescale 1ns/1ps

// ***************************************************************
// Port-level checks of the status and configuration bank
// ***************************************************************
module fscr_regs_checker (
	input wire logic       clk,
	input wire logic       resetn,
	input wire logic       por_n,
	input wire logic       nv_clear_n,
	input wire logic       prog_busy,
	input wire logic       erase_busy,
	input wire logic       prog_issue,
	input wire logic       erase_issue,
	input wire logic       prog_fail,
	input wire logic       erase_fail,
	input wire logic       op_busy_flag,
	input wire logic       write_latch,
	input wire logic       quad_io_on,
	input wire logic       upper_addr_bit,
	input wire logic       addr_mode_now,
	input wire logic       addr_top_bit,
	input wire logic [2:0] secure_lock,
	input wire logic       erase_suspended,
	input wire logic       program_suspended,
	input wire logic       program_fail,
	input wire logic       erase_fail_flag,
	input wire logic       suspend_pulse,
	input wire logic       resume_pulse,
	input wire logic [3:0] dual_dummy,
	input wire logic [3:0] quad_dummy,
	input wire logic [6:0] drive_pct
);
	// Any of the three resets masks the checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn || !por_n || !nv_clear_n);

	busy_reflect_a: assert property ((prog_busy || erase_busy) |-> op_busy_flag)
		else $error("busy flag low while the array engine runs");
	quad_fixed_a: assert property (quad_io_on)
		else $error("quad enable not held at one");
	top_bit_sel_a: assert property (addr_top_bit == (upper_addr_bit && !addr_mode_now))
		else $error("top address bit does not follow mode and extended bit");
	dummy_pair_a: assert property ((dual_dummy == 4'h4 && quad_dummy == 4'h6) ||
		(dual_dummy == 4'h8 && quad_dummy == 4'ha))
		else $error("dummy counts out of pairing");
	drive_code_a: assert property (drive_pct inside {7'h64, 7'h4b, 7'h32, 7'h19})
		else $error("drive strength outside its table");
	lock_sticky_a: assert property ((secure_lock & $past(secure_lock)) == $past(secure_lock))
		else $error("a set lock bit cleared");
	latch_drop_a: assert property ((prog_issue || erase_issue) |-> ##[0:2] !write_latch)
		else $error("write latch kept after program or erase");
	pfail_set_a: assert property (prog_fail |-> ##[0:2] program_fail)
		else $error("program fail flag not set");
	efail_set_a: assert property (erase_fail |-> ##[0:2] erase_fail_flag)
		else $error("erase fail flag not set");
	resume_clr_a: assert property (resume_pulse |-> ##[0:2]
		(!erase_suspended && !program_suspended))
		else $error("suspend flags kept after resume");
	esusp_set_a: assert property ((suspend_pulse && erase_busy && !prog_busy) |->
		##[0:2] erase_suspended)
		else $error("erase suspend flag not set");
	pulse_once_a: assert property ((suspend_pulse || resume_pulse) |=>
		!(suspend_pulse || resume_pulse))
		else $error("suspend or resume pulse longer than one cycle");

	// Main scenarios reached
	cover property (erase_suspended);
	cover property (program_fail);
	cover property ($rose(addr_mode_now));
	cover property (resume_pulse);
endmodule : fscr_regs_checker

// ===== verif/fscr_host_model.sv
`timescale 1ns/1ps

// ***************************************************************
// Serial host, mode 0, clock still outside frames
// ***************************************************************
module fscr_host_model (
	output logic      sclk,
	output logic      cs_n,
	output logic      si,
	input  wire logic so,
	input  wire logic so_oe
);
	// Idle bus: deselected, clock low
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		si   = 1'b0;
	end

	// One frame: nb 1 = opcode, 2 = opcode + data, 3 = opcode + read byte
	task automatic frame(input logic [7:0] op, input logic [7:0] wd, input int nb,
		output logic [7:0] rd);
		logic [15:0] sh;
		int          n;
		sh   = {op, wd};
		n    = (nb == 1) ? 8 : 16;
		rd   = 8'h00;
		cs_n = 1'b0;
		for (int i = 0; i < n; i++) begin
			si = (nb == 3 && i >= 8) ? i[0] : sh[15-i]; // Toggling filler, no stale value
			#24 sclk = 1'b1;
			if (i >= 8)
				rd = {rd[6:0], (so_oe === 1'b1) ? so : 1'bx}; // Undriven line never matches
			#24 sclk = 1'b0;
		end
		#24 cs_n = 1'b1;
		si = ~si;
		#250;
	endtask : frame
endmodule : fscr_host_model

// ===== verif/fscr_regs_tb_top.sv
`timescale 1ns/1ps
`include "fscr_cfg.svh"

// ***************************************************************
// Register bank bench
// ***************************************************************
module fscr_regs_tb_top
	import fscr_pkg::*;
;
	logic       clk, resetn, por_n, nv_clear_n, sclk, cs_n, si, so, so_oe;
	logic       prog_busy, erase_busy, prog_issue, erase_issue, prog_fail, erase_fail;
	logic       op_busy_flag, write_latch, addr_mode_now, quad_io_on, upper_addr_bit;
	logic       addr_top_bit, erase_suspended, program_suspended, program_fail;
	logic       erase_fail_flag, suspend_pulse, resume_pulse;
	logic [4:0] protect_sel;
	logic [2:0] secure_lock;
	logic [3:0] dual_dummy, quad_dummy;
	logic [6:0] drive_pct;
	logic [7:0] rb, v;
	logic [7:0] pct [4] = '{8'h64, 8'h4b, 8'h32, 8'h19};
	int         mismatches, n_checks;

	fscr_regs DUT (.*);
	fscr_host_model u_host (.*);

	// Core clock, 50 ns
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic stop_test;
		$display("mismatches=%0d n_checks=%0d", mismatches, n_checks);
		if (mismatches == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : stop_test

	task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD reg t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_reg

	task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD pin t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_pin

	task automatic ticks(input int n);
		repeat (n) @(negedge clk);
	endtask : ticks

	// Bounded wait for the status write timer to run out
	task automatic wait_idle;
		int i;
		ticks(2);
		for (i = 0; i < 60 && op_busy_flag !== 1'b0; i++)
			ticks(1);
		if (i == 60) begin
			mismatches++;
			$display("BAD busy t=%0t got=%h exp=%h", $time, op_busy_flag, 1'b0);
			stop_test;
		end
	endtask : wait_idle

	task automatic cmd(input logic [7:0] op);
		u_host.frame(op, 8'h00, 1, rb);
		ticks(6); // Covers the sync latency
	endtask : cmd

	task automatic wr(input logic [7:0] op, input logic [7:0] d);
		u_host.frame(op, d, 2, rb);
		wait_idle;
	endtask : wr

	task automatic wen_wr(input logic [7:0] op, input logic [7:0] d);
		cmd(`FSCR_OP_WRITE_ENABLE_CMD);
		wr(op, d);
	endtask : wen_wr

	task automatic rd_chk(input logic [7:0] op, input logic [7:0] exp);
		u_host.frame(op, 8'h00, 3, rb);
		chk_reg(rb, exp);
	endtask : rd_chk

	// One-cycle pulse from the array engine side
	task automatic strobe(ref logic s);
		@(negedge clk) s = 1'b1;
		@(negedge clk) s = 1'b0;
		ticks(3);
	endtask : strobe

	task automatic rst_pulse(input bit power);
		@(negedge clk);
		if (power) por_n = 1'b0;
		else resetn = 1'b0;
		ticks(4);
		por_n  = 1'b1;
		resetn = 1'b1;
		ticks(4);
	endtask : rst_pulse

	// Cuts a hang short
	initial begin
		#3000000;
		mismatches++;
		$display("BAD timeout t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
		stop_test;
	end

	// Main sequence
	initial begin
		mismatches = 0;
		n_checks = 0;
		{resetn, por_n, nv_clear_n} = 3'h0;
		{prog_busy, erase_busy, prog_issue, erase_issue, prog_fail, erase_fail} = 6'h00;
		ticks(16);
		{resetn, por_n, nv_clear_n} = 3'h7;
		ticks(4);
		rd_chk(`FSCR_OP_RD_SR1, 8'h00);
		rd_chk(`FSCR_OP_RD_SR2, 8'h02);
		rd_chk(`FSCR_OP_RD_SR3, 8'h20);
		rd_chk(`FSCR_OP_RD_EA, 8'h00);
		chk_pin(8'(drive_pct), 8'h4b);
		wr(`FSCR_OP_WR_SR1, 8'h1c);
		rd_chk(`FSCR_OP_RD_SR1, 8'h00);
		cmd(`FSCR_OP_WRITE_ENABLE_CMD);
		rd_chk(`FSCR_OP_RD_SR1, 8'h02);
		u_host.frame(`FSCR_OP_WR_SR1, 8'h1f, 2, rb);
		ticks(2);
		chk_pin(8'(op_busy_flag), 8'h01);
		wait_idle;
		rd_chk(`FSCR_OP_RD_SR1, 8'h1c);
		chk_pin(8'(protect_sel), 8'h07);
		wen_wr(`FSCR_OP_WR_SR2, 8'h2b);
		rd_chk(`FSCR_OP_RD_SR2, 8'h2a);
		wen_wr(`FSCR_OP_WR_SR2, 8'h00);
		rd_chk(`FSCR_OP_RD_SR2, 8'h2a);
		chk_pin(8'(secure_lock), 8'h05);
		// Every drive and dummy code, reserved bit kept at zero
		for (int i = 0; i < 4; i++) begin
			v = {1'b0, i[1:0], 3'h0, i[1:0]};
			wen_wr(`FSCR_OP_WR_SR3, v);
			rd_chk(`FSCR_OP_RD_SR3, v);
			chk_pin(8'(drive_pct), pct[i]);
			chk_pin(8'(dual_dummy), i[0] ? 8'h08 : 8'h04);
			chk_pin(8'(quad_dummy), i[0] ? 8'h0a : 8'h06);
		end
		wr(`FSCR_OP_WR_EA, 8'h01);
		rd_chk(`FSCR_OP_RD_EA, 8'h01);
		chk_pin(8'(addr_top_bit), 8'h01);
		cmd(`FSCR_OP_EN4B);
		chk_pin({6'h0, addr_mode_now, addr_top_bit}, 8'h02);
		rd_chk(`FSCR_OP_RD_SR2, 8'h2b);
		cmd(`FSCR_OP_EX4B);
		chk_pin(8'(addr_mode_now), 8'h00);
		wen_wr(`FSCR_OP_WR_SR3, 8'h30);
		rst_pulse(1'b0);
		chk_pin({6'h0, addr_mode_now, upper_addr_bit}, 8'h02);
		rd_chk(`FSCR_OP_RD_SR1, 8'h1c);
		cmd(`FSCR_OP_EX4B);
		// Erase suspended with an error, then resumed
		erase_busy = 1'b1;
		cmd(`FSCR_OP_SUSPEND);
		chk_pin({6'h0, erase_suspended, program_suspended}, 8'h02);
		strobe(erase_fail);
		rd_chk(`FSCR_OP_RD_SR2, 8'haa);
		rd_chk(`FSCR_OP_RD_SR3, 8'h38);
		cmd(`FSCR_OP_RESUME);
		chk_pin({5'h0, erase_suspended, program_suspended, erase_fail_flag}, 8'h00);
		erase_busy = 1'b0;
		prog_busy = 1'b1;
		cmd(`FSCR_OP_SUSPEND);
		strobe(prog_fail);
		chk_pin({6'h0, program_suspended, program_fail}, 8'h03);
		cmd(`FSCR_OP_RST_EN);
		cmd(`FSCR_OP_RST);
		chk_pin(8'(program_suspended), 8'h00);
		prog_busy = 1'b0;
		cmd(`FSCR_OP_EX4B);
		// Latch dropped by program, erase and disable
		cmd(`FSCR_OP_WRITE_ENABLE_CMD);
		chk_pin(8'(write_latch), 8'h01);
		strobe(prog_issue);
		chk_pin(8'(write_latch), 8'h00);
		cmd(`FSCR_OP_WRITE_ENABLE_CMD);
		strobe(erase_issue);
		chk_pin(8'(write_latch), 8'h00);
		cmd(`FSCR_OP_WRITE_ENABLE_CMD);
		cmd(`FSCR_OP_WRDI);
		chk_pin(8'(write_latch), 8'h00);
		// Lock-down until a power cycle
		wen_wr(`FSCR_OP_WR_SR2, 8'h6a);
		rd_chk(`FSCR_OP_RD_SR2, 8'h6a);
		wen_wr(`FSCR_OP_WR_SR1, 8'h00);
		rd_chk(`FSCR_OP_RD_SR1, 8'h1e);
		rst_pulse(1'b1);
		rd_chk(`FSCR_OP_RD_SR2, 8'h2b);
		wen_wr(`FSCR_OP_WR_SR1, 8'h00);
		rd_chk(`FSCR_OP_RD_SR1, 8'h00);
		stop_test;
	end
endmodule : fscr_regs_tb_top

bind fscr_regs fscr_regs_checker u_chk (.*);
